// file: ommc_pkg.sv
package ommc_pkg;

  // Control port address on the processor I/O space.
  localparam logic [7:0] CTRL_PORT_ADDR = 8'h16;

  // Control port field positions.
  localparam int BANK_EN_LSB = 0;
  localparam int BANK_EN_W = 4;
  localparam int ROM_OFF_BIT = 5;
  localparam int MEM_EN_BIT = 6;

  // Values software writes to switch the boot ROM.
  localparam logic [7:0] CTRL_ROM_ON = 8'h4F;
  localparam logic [7:0] CTRL_ROM_OFF = 8'h6F;

  // Values after reset.
  localparam logic [3:0] BANK_EN_RST = 4'hF;
  localparam logic MEM_EN_RST = 1'b1;
  localparam logic ROM_EN_RST = 1'b1;
  localparam logic POJ_RST = 1'b1;

  // Address map.
  localparam logic [15:0] ROM_WIN_BASE = 16'hF000;
  localparam logic [15:0] ROM_WIN_LAST = 16'hFFFF;
  localparam logic [15:0] ROM_DECODE_BASE = 16'hF800;
  localparam int ROM_ADDR_W = 12;
  localparam int ROM_2K_ADDR_W = 11;

  // Dynamic RAM geometry: low address bits form the row.
  localparam int ROW_W = 7;
  localparam int COL_W = 9;
  localparam logic [ROW_W-1:0] ROW_RST = 7'h00;
  localparam int REFRESH_ROWS = 128;

  // One processor-side bus sample per clock.
  typedef struct packed {
    logic mem_cycle;
    logic write;
    logic io_write;
    logic [15:0] addr;
    logic [7:0] data;
    logic opcode_fetch_cycle;
    logic wait_state;
    logic phantom;
    logic dma_active;
  } ommc_bus_s;

  // Decoded memory strobes toward the RAM and ROM.
  typedef struct packed {
    logic ram_select;
    logic ram_write;
    logic [ROW_W-1:0] ram_row;
    logic [COL_W-1:0] ram_col;
    logic rom_select;
    logic [ROM_ADDR_W-1:0] rom_addr;
  } ommc_mem_s;

  // Refresh row counter state.
  typedef struct packed {
    logic rst_phase;
    logic strobe;
    logic [ROW_W-1:0] row;
  } ommc_ref_s;

endpackage : ommc_pkg

// file: ommc_refresh.sv
`timescale 1ns/100ps

// Refresh row generator. It keeps counting while reset is held so the
// array is not starved during a long reset.
module ommc_refresh (
  input wire logic clk,
  input wire logic nrst,
  input wire logic refresh_req,
  output logic refresh_strobe,
  output logic [ommc_pkg::ROW_W-1:0] refresh_row
);

  ommc_pkg::ommc_ref_s st;
  ommc_pkg::ommc_ref_s next_st;

  // In reset the first cycle clears the row, later reset cycles advance it.
  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    if (!nrst) begin
      next_st.strobe = 1'b1;
      if (st.rst_phase) begin
        next_st.row = ommc_pkg::ROW_W'(st.row + 1'b1);
      end else begin
        next_st.row = ommc_pkg::ROW_RST;
        next_st.rst_phase = 1'b1;
      end
    end else begin
      next_st.rst_phase = 1'b0;
      if (refresh_req) begin
        next_st.strobe = 1'b1;
        next_st.row = ommc_pkg::ROW_W'(st.row + 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign refresh_strobe = st.strobe;
  assign refresh_row = st.row;

endmodule : ommc_refresh

// file: ommc_ctrl.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Four 16K RAM banks enable independently.
// - Disabled bank leaves its range to bus.
// - Refresh on opcode fetch, wait, reset.
// - External DMA masters reach onboard RAM.
// - Low address bits form RAM row.
// - Reset switches monitor ROM on.
// - Enabled ROM occupies F000h to FFFFh.
// - Disabled ROM decodes nothing; RAM visible.
// - ROM may switch any time.
// - Writing 4Fh to port 16h: ROM on.
// - Writing 6Fh to port: ROM off.
// - Both writes cancel jump, enable memory.
// - ROM decode base fixed at F000h.
// - 2K ROM part appears twice mirrored.
// - Strap selects 2K or 4K ROM.
// - Onboard RAM yields to PHANTOM.
module ommc_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire ommc_pkg::ommc_bus_s bus,
  input wire logic rom_is_4k,
  output ommc_pkg::ommc_mem_s mem,
  output logic [3:0] bank_enable,
  output logic mem_enable,
  output logic rom_enable,
  output logic power_on_jump,
  output logic refresh_strobe,
  output logic [ommc_pkg::ROW_W-1:0] refresh_row
);

  // Control and decode state in one record, so hold is a single assignment and reset one assignment per field.
  typedef struct packed {
    logic [3:0] bank_en;
    logic mem_en;
    logic rom_en;
    logic poj;
    ommc_pkg::ommc_mem_s mem;
  } ommc_state_s;

  ommc_state_s st;
  ommc_state_s next_st;
  logic ctrl_wr;
  logic rom_hit;
  logic refresh_req;

  // True when the address falls in the ROM window.
  function automatic logic in_rom_window(input logic [15:0] a);
    in_rom_window = (a >= ommc_pkg::ROM_WIN_BASE) && (a <= ommc_pkg::ROM_WIN_LAST);
  endfunction : in_rom_window

  // Selects the bank enable bit for an address.
  function automatic logic bank_on(input logic [3:0] en, input logic [15:0] a);
    bank_on = en[a[15:14]];
  endfunction : bank_on

  // ROM chip address; a 2K part ignores A11, so it is seen twice.
  function automatic logic [ommc_pkg::ROM_ADDR_W-1:0] rom_index(input logic big, input logic [15:0] a);
    if (big) begin
      rom_index = a[ommc_pkg::ROM_ADDR_W-1:0];
    end else begin
      rom_index = {1'b0, a[ommc_pkg::ROM_2K_ADDR_W-1:0]};
    end
  endfunction : rom_index

  // Control port write and ROM decode; DMA masters never see the ROM.
  assign ctrl_wr = bus.io_write && (bus.addr[7:0] == ommc_pkg::CTRL_PORT_ADDR);
  assign rom_hit = st.rom_en && !bus.dma_active && in_rom_window(bus.addr);
  assign refresh_req = bus.opcode_fetch_cycle || bus.wait_state;

  // Next state: control port and per-cycle decode, registered so every
  // output leaves a flip-flop. The decode is one clock behind the bus.
  always_comb begin
    next_st = st;
    next_st.mem.ram_select = 1'b0;
    next_st.mem.ram_write = 1'b0;
    next_st.mem.rom_select = 1'b0;
    if (ctrl_wr) begin
      next_st.bank_en = bus.data[ommc_pkg::BANK_EN_LSB +: ommc_pkg::BANK_EN_W];
      next_st.mem_en = bus.data[ommc_pkg::MEM_EN_BIT];
      next_st.rom_en = !bus.data[ommc_pkg::ROM_OFF_BIT];
      next_st.poj = 1'b0;
    end
    if (bus.mem_cycle) begin
      next_st.mem.ram_row = bus.addr[ommc_pkg::ROW_W-1:0];
      next_st.mem.ram_col = bus.addr[15:ommc_pkg::ROW_W];
      if (rom_hit) begin
        next_st.mem.rom_select = !bus.write;
        next_st.mem.rom_addr = rom_index(rom_is_4k, bus.addr);
      end else if (st.mem_en && bank_on(st.bank_en, bus.addr) && !bus.phantom) begin
        next_st.mem.ram_select = 1'b1;
        next_st.mem.ram_write = bus.write;
      end
    end
    if (!nrst) begin
      next_st.bank_en = ommc_pkg::BANK_EN_RST;
      next_st.mem_en = ommc_pkg::MEM_EN_RST;
      next_st.rom_en = ommc_pkg::ROM_EN_RST;
      next_st.poj = ommc_pkg::POJ_RST;
      next_st.mem = '0;
    end
  end

  // State register, synchronous reset folded into the next-state logic.
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Refresh rows run from their own counter.
  ommc_refresh u_refresh (
    .clk(clk),
    .nrst(nrst),
    .refresh_req(refresh_req),
    .refresh_strobe(refresh_strobe),
    .refresh_row(refresh_row)
  );

  // Outputs are state fields.
  assign mem = st.mem;
  assign bank_enable = st.bank_en;
  assign mem_enable = st.mem_en;
  assign rom_enable = st.rom_en;
  assign power_on_jump = st.poj;

  // Checks on the decode and control port.
  property p_reset_rom_on;
    @(posedge clk) !nrst |=> rom_enable && power_on_jump && (bank_enable == 4'hF);
  endproperty
  a_reset_rom_on: assert property (p_reset_rom_on) else $error("ROM or banks not on after reset");

  property p_rom_on_write;
    @(posedge clk) disable iff (!nrst)
      (ctrl_wr && bus.data == ommc_pkg::CTRL_ROM_ON) |=> rom_enable && !power_on_jump && mem_enable;
  endproperty
  a_rom_on_write: assert property (p_rom_on_write) else $error("ROM on write not honoured");

  property p_rom_off_write;
    @(posedge clk) disable iff (!nrst)
      (ctrl_wr && bus.data == ommc_pkg::CTRL_ROM_OFF) |=> !rom_enable && !power_on_jump && mem_enable;
  endproperty
  a_rom_off_write: assert property (p_rom_off_write) else $error("ROM off write not honoured");

  property p_bank_off;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && !rom_hit && !bank_on(bank_enable, bus.addr)) |=> !mem.ram_select;
  endproperty
  a_bank_off: assert property (p_bank_off) else $error("Disabled bank answered");

  property p_bank_on;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && !rom_hit && mem_enable && bank_on(bank_enable, bus.addr) && !bus.phantom)
      |=> mem.ram_select && (mem.ram_write == $past(bus.write));
  endproperty
  a_bank_on: assert property (p_bank_on) else $error("Enabled bank did not answer");

  property p_phantom;
    @(posedge clk) disable iff (!nrst) (bus.mem_cycle && bus.phantom) |=> !mem.ram_select;
  endproperty
  a_phantom: assert property (p_phantom) else $error("RAM ignored PHANTOM");

  property p_rom_window;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && !bus.write && rom_enable && !bus.dma_active && bus.addr >= ommc_pkg::ROM_WIN_BASE)
      |=> mem.rom_select && !mem.ram_select;
  endproperty
  a_rom_window: assert property (p_rom_window) else $error("ROM window not decoded");

  property p_rom_off_ram;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && !rom_enable) |=> !mem.rom_select;
  endproperty
  a_rom_off_ram: assert property (p_rom_off_ram) else $error("Disabled ROM decoded");

  property p_mirror;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && rom_hit && !bus.write && !rom_is_4k) |=> !mem.rom_addr[11] &&
        (mem.rom_addr[10:0] == $past(bus.addr[10:0]));
  endproperty
  a_mirror: assert property (p_mirror) else $error("2K ROM not mirrored");

  property p_row_low;
    @(posedge clk) disable iff (!nrst)
      bus.mem_cycle |=> (mem.ram_row == $past(bus.addr[6:0])) && (mem.ram_col == $past(bus.addr[15:7]));
  endproperty
  a_row_low: assert property (p_row_low) else $error("Row not from low address");

  property p_refresh;
    @(posedge clk) (!nrst || bus.opcode_fetch_cycle || bus.wait_state) |=> refresh_strobe;
  endproperty
  a_refresh: assert property (p_refresh) else $error("Refresh missed");

  property p_dma_ram;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && bus.dma_active && mem_enable && bank_on(bank_enable, bus.addr) && !bus.phantom)
      |=> mem.ram_select;
  endproperty
  a_dma_ram: assert property (p_dma_ram) else $error("DMA refused onboard RAM");

  // Control state moves only on a control port write; between writes it must
  // hold, since software never reads it back.
  property p_ctrl_hold;
    @(posedge clk) disable iff (!nrst)
      !ctrl_wr |=> $stable({bank_enable, mem_enable, rom_enable, power_on_jump});
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control state moved without a write");

  // Only reset may raise the jump flag again; a stray set would restart the boot.
  property p_poj_low;
    @(posedge clk) disable iff (!nrst) !power_on_jump |=> !power_on_jump;
  endproperty
  a_poj_low: assert property (p_poj_low) else $error("Power-on jump came back");

  // Field map of the control byte, checked against the byte of the previous edge.
  property p_ctrl_fields;
    @(posedge clk) disable iff (!nrst)
      ctrl_wr |=> (bank_enable == $past(bus.data[ommc_pkg::BANK_EN_LSB +: ommc_pkg::BANK_EN_W]))
        && (mem_enable == $past(bus.data[ommc_pkg::MEM_EN_BIT]))
        && (rom_enable == !$past(bus.data[ommc_pkg::ROM_OFF_BIT]));
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("Control port fields misplaced");

  // Refresh row moves by one per request and wraps after the last row.
  property p_row_step;
    @(posedge clk) disable iff (!nrst)
      (bus.opcode_fetch_cycle || bus.wait_state) |=> refresh_row == ommc_pkg::ROW_W'($past(refresh_row) + 1'b1);
  endproperty
  a_row_step: assert property (p_row_step) else $error("Refresh row did not step");

  // A stray refresh strobe would steal a memory cycle for nothing.
  property p_refresh_quiet;
    @(posedge clk) disable iff (!nrst)
      !(bus.opcode_fetch_cycle || bus.wait_state) |=> !refresh_strobe;
  endproperty
  a_refresh_quiet: assert property (p_refresh_quiet) else $error("Refresh strobe without a request");

  // Never both selects: the ROM and the RAM share the data bus.
  property p_one_select;
    @(posedge clk) disable iff (!nrst) !(mem.ram_select && mem.rom_select);
  endproperty
  a_one_select: assert property (p_one_select) else $error("RAM and ROM selected together");

  property p_write_sel;
    @(posedge clk) disable iff (!nrst) mem.ram_write |-> mem.ram_select;
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("RAM write strobe without select");

  // Selects last one cycle; a standing select would stretch a RAM cycle.
  property p_idle_drop;
    @(posedge clk) disable iff (!nrst) !bus.mem_cycle |=> !mem.ram_select && !mem.rom_select;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("Select held without a memory cycle");

  property p_rom_no_write;
    @(posedge clk) disable iff (!nrst) (bus.mem_cycle && bus.write) |=> !mem.rom_select;
  endproperty
  a_rom_no_write: assert property (p_rom_no_write) else $error("Write selected the ROM");

  // The ROM is the processor's alone; DMA masters see RAM under the window.
  property p_dma_no_rom;
    @(posedge clk) disable iff (!nrst) (bus.mem_cycle && bus.dma_active) |=> !mem.rom_select;
  endproperty
  a_dma_no_rom: assert property (p_dma_no_rom) else $error("DMA cycle selected the ROM");

  // Clearing the memory enable bit hides the whole array.
  property p_mem_off;
    @(posedge clk) disable iff (!nrst) (bus.mem_cycle && !mem_enable) |=> !mem.ram_select;
  endproperty
  a_mem_off: assert property (p_mem_off) else $error("Disabled memory answered");

  // A 4K part uses all twelve address lines, so nothing is mirrored.
  property p_rom_4k;
    @(posedge clk) disable iff (!nrst)
      (bus.mem_cycle && rom_hit && !bus.write && rom_is_4k) |=> mem.rom_addr == $past(bus.addr[11:0]);
  endproperty
  a_rom_4k: assert property (p_rom_4k) else $error("4K ROM address wrong");

  // Reset must not leave a select standing, or the array could be written.
  property p_reset_clear;
    @(posedge clk) !nrst |=> !mem.ram_select && !mem.rom_select && !mem.ram_write;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Strobes left on in reset");

  // Row and column hold between cycles, so the array sees a steady address.
  property p_row_hold;
    @(posedge clk) disable iff (!nrst)
      !bus.mem_cycle |=> $stable(mem.ram_row) && $stable(mem.ram_col) && $stable(mem.rom_addr);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("Memory address moved while idle");

  // Main scenarios.
  c_rom_off: cover property (@(posedge clk) disable iff (!nrst) ctrl_wr ##1 !rom_enable);
  c_rom_read: cover property (@(posedge clk) disable iff (!nrst) mem.rom_select);
  c_dma_write: cover property (@(posedge clk) disable iff (!nrst) bus.dma_active && bus.mem_cycle ##1 mem.ram_write);
  c_bank_off: cover property (@(posedge clk) disable iff (!nrst) bank_enable != 4'hF);
  c_row_wrap: cover property (@(posedge clk) disable iff (!nrst) refresh_strobe && refresh_row == '0);

endmodule : ommc_ctrl

// file: ommc_cpu_model.sv
`timescale 1ns/100ps

// Local processor or bus DMA master in front of the block.
// It makes one bus cycle per call and leaves one idle edge between calls.
module ommc_cpu_model (
  input wire logic clk,
  output ommc_pkg::ommc_bus_s bus
);
  // The bus starts idle with all strobes low.
  initial begin
    bus = '0;
  end

  // A DMA master here moves a byte at most every other clock, far inside the average rate it must keep.
  task automatic cycle(input ommc_pkg::ommc_bus_s v);
    ommc_pkg::ommc_bus_s r;
    @(posedge clk);
    #1;
    bus = v;
    @(posedge clk);
    #1;
    // Released lines show the inverse so a stale value is never mistaken for a live one.
    r = '0;
    r.addr = ~v.addr;
    r.data = ~v.data;
    bus = r;
  endtask : cycle
endmodule : ommc_cpu_model

// file: onboard_memory_map_control_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end

module onboard_memory_map_control_tb;
  // Flag order: mem_cycle write io_write opcode_fetch wait phantom dma.
  localparam logic [6:0] MRD = 7'h40;
  localparam logic [6:0] MWR = 7'h60;
  localparam logic [6:0] OFC = 7'h48;
  localparam logic [6:0] WST = 7'h04;
  localparam logic [6:0] PHM = 7'h42;
  localparam logic [6:0] DMA = 7'h41;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rom_is_4k = 1'b0;
  ommc_pkg::ommc_bus_s bus;
  ommc_pkg::ommc_mem_s mem;
  logic [3:0] bank_enable;
  logic mem_enable, rom_enable, power_on_jump, refresh_strobe;
  logic [ommc_pkg::ROW_W-1:0] refresh_row;
  logic [ommc_pkg::ROW_W-1:0] exp_row;
  int fail_count = 0;
  int tests_run = 0;

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  ommc_cpu_model cpu (.clk(clk), .bus(bus));
  ommc_ctrl uut (.clk(clk), .nrst(nrst), .bus(bus), .rom_is_4k(rom_is_4k), .mem(mem),
    .bank_enable(bank_enable), .mem_enable(mem_enable), .rom_enable(rom_enable),
    .power_on_jump(power_on_jump), .refresh_strobe(refresh_strobe), .refresh_row(refresh_row));

  function automatic ommc_pkg::ommc_bus_s mk(input logic [15:0] a, input logic [7:0] d, input logic [6:0] f);
    ommc_pkg::ommc_bus_s v;
    v = '0;
    v.addr = a;
    v.data = d;
    {v.mem_cycle, v.write, v.io_write, v.opcode_fetch_cycle, v.wait_state, v.phantom, v.dma_active} = f;
    return v;
  endfunction : mk

  task automatic mcyc(input logic [15:0] a, input logic [6:0] f);
    cpu.cycle(mk(a, 8'h00, f));
  endtask : mcyc

  task automatic iow(input logic [7:0] d);
    cpu.cycle(mk(16'h0016, d, 7'h10));
  endtask : iow

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short well after the few hundred cycles the sequence needs.
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  // Reset for six edges, then walk the map, the control port and refresh.
  initial begin
    repeat (2) @(posedge clk);
    #1;
    `CHK(refresh_strobe, 1'b1)
    `CHK({bank_enable, mem_enable, rom_enable, power_on_jump}, 7'h7F)
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    exp_row = 7'h05;
    `CHK(refresh_row, exp_row)
    mcyc(16'hF123, MRD);
    `CHK({mem.rom_select, mem.ram_select, mem.rom_addr}, 14'h2123)
    mcyc(ommc_pkg::ROM_DECODE_BASE | 16'h0123, MRD);
    `CHK({mem.rom_select, mem.ram_select, mem.rom_addr}, 14'h2123)
    rom_is_4k = 1'b1;
    mcyc(16'hF923, MRD);
    `CHK({mem.rom_select, mem.ram_select, mem.rom_addr}, 14'h2923)
    mcyc(16'hF000, DMA);
    `CHK({mem.rom_select, mem.ram_select}, 2'b01)
    mcyc(16'hF000, DMA | MWR);
    `CHK({mem.rom_select, mem.ram_select, mem.ram_write}, 3'b011)
    iow(8'h6F);
    `CHK({rom_enable, power_on_jump, mem_enable, bank_enable}, 7'h1F)
    mcyc(16'hF123, MWR);
    `CHK({mem.rom_select, mem.ram_select, mem.ram_write, mem.ram_row, mem.ram_col}, {3'b011, 7'h23, 9'h1E2})
    iow(8'h4F);
    `CHK({rom_enable, power_on_jump}, 2'b10)
    mcyc(16'hF123, MRD);
    `CHK(mem.rom_select, 1'b1)
    // Turn each bank off in turn with the ROM out of the way.
    for (int n = 0; n < 4; n++) begin
      iow(8'h60 | (8'h0F ^ (8'h01 << n)));
      `CHK(bank_enable, 4'hF ^ (4'h1 << n))
      mcyc({n[1:0], 14'h0100}, MRD);
      `CHK(mem.ram_select, 1'b0)
      mcyc({n[1:0] + 2'd1, 14'h0100}, MRD);
      `CHK(mem.ram_select, 1'b1)
    end
    iow(8'h6F);
    mcyc(16'h4000, PHM);
    `CHK(mem.ram_select, 1'b0)
    iow(8'h2F);
    mcyc(16'h4000, MRD);
    `CHK({mem_enable, mem.ram_select}, 2'b00)
    // A reset in mid-run must bring the ROM, the banks and the memory back.
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    `CHK({bank_enable, mem_enable, rom_enable, power_on_jump}, 7'h7F)
    `CHK({refresh_strobe, refresh_row}, 8'h81)
    exp_row = 7'h01;
    // More than a full row sweep, so the row count must wrap after 128.
    for (int i = 0; i < 130; i++) begin
      mcyc(16'h0100, i[0] ? OFC : WST);
      exp_row = exp_row + 7'h01;
      `CHK({refresh_strobe, refresh_row}, {1'b1, exp_row})
    end
    @(posedge clk);
    #1;
    `CHK(refresh_strobe, 1'b0)
    end_sim();
  end
endmodule : onboard_memory_map_control_tb
